// ---- rtl/ext_alu_defs.svh ----
`ifndef EXT_ALU_DEFS_SVH
`define EXT_ALU_DEFS_SVH

// far address: section number plus byte offset inside the section
`define EXT_SECT_W       3
`define EXT_OFS_W        8
`define EXT_ADDR_W       11
`define EXT_DATA_W       8
`define EXT_BIT_W        3

// apb register byte offsets
`define APB_ADDR_W       8
`define REG_CTRL_OFS     8'h00
`define REG_WORK_OFS     8'h04
`define REG_FLAGS_OFS    8'h08
`define REG_STATUS_OFS   8'h0c

// ctrl fields
`define CTRL_ENABLE_BIT  0
`define CTRL_RESET_VAL   1'b1

// flags register layout
`define FLAG_WRAP_OUT    0
`define FLAG_HALF_CARRY  1
`define FLAG_RESULT_NULL 2
`define FLAG_SIGNED_RNG  3
`define FLAG_SIGNED_RES  4
`define FLAGS_W          5
`define FLAGS_RESET_VAL  5'h00

// work register reset value
`define WORK_RESET_VAL   8'h00

// status fields
`define STAT_BUSY_BIT    0
`define STAT_STATE_LSB   1
`define STAT_LAST_OP_LSB 4
`define STAT_COUNT_LSB   8
`define STAT_COUNT_W     8

`endif

// ---- rtl/ext_alu_pkg.sv ----
package ext_alu_pkg;
`include "ext_alu_defs.svh"

	typedef enum logic [2:0] {
		far_add_with_carry_to_work   = 3'b000,
		far_add_with_carry_to_memory = 3'b001,
		far_add_to_work              = 3'b010,
		far_add_to_memory            = 3'b011,
		far_and_to_work              = 3'b100,
		far_and_to_memory            = 3'b101,
		far_clear_byte               = 3'b110,
		far_clear_bit                = 3'b111
	} ext_op_t;

	typedef enum logic [1:0] {
		st_idle  = 2'b00,
		st_fetch = 2'b01,
		st_exec  = 2'b10
	} ext_state_t;

	// bit order matches the flags register layout
	typedef struct packed {
		logic signed_result;
		logic signed_range;
		logic result_null;
		logic half_carry;
		logic wrap_out;
	} flags_t;

	typedef struct packed {
		ext_op_t                  op;
		logic [`EXT_SECT_W-1:0]   section;
		logic [`EXT_OFS_W-1:0]    offset;
		logic [`EXT_BIT_W-1:0]    bit_sel;
	} ext_req_t;

	typedef struct packed {
		logic                     rd;
		logic                     wr;
		logic [`EXT_ADDR_W-1:0]   addr;
		logic [`EXT_DATA_W-1:0]   wdata;
	} mem_cmd_t;

endpackage

// ---- rtl/ext_alu_calc.sv ----
`timescale 1ns/1ns
`include "ext_alu_defs.svh"

module ext_alu_calc
	import ext_alu_pkg::*;
(
	input  wire ext_op_t                 op,
	input  wire logic [`EXT_DATA_W-1:0]  work,
	input  wire logic [`EXT_DATA_W-1:0]  mem,
	input  wire flags_t                  flags_in,
	input  wire logic [`EXT_BIT_W-1:0]   bit_sel,
	output logic      [`EXT_DATA_W-1:0]  result,
	output flags_t                       flags_out,
	output logic                         to_mem
);

	logic                     is_carry;
	logic                     is_add;
	logic                     is_and;
	logic                     cin;
	logic [`EXT_DATA_W:0]     sum9;
	logic [4:0]               low5;
	logic                     ovf;
	logic [`EXT_DATA_W-1:0]   and_res;
	logic [`EXT_DATA_W-1:0]   keep_mask;
	logic                     null_res;

	assign is_carry = (op == far_add_with_carry_to_work) || (op == far_add_with_carry_to_memory);
	assign is_add   = is_carry || (op == far_add_to_work) || (op == far_add_to_memory);
	assign is_and   = (op == far_and_to_work) || (op == far_and_to_memory);

	assign cin  = is_carry & flags_in.wrap_out;
	assign sum9 = {1'b0, work} + {1'b0, mem} + {8'h00, cin};
	assign low5 = {1'b0, work[3:0]} + {1'b0, mem[3:0]} + {4'h0, cin};
	assign ovf  = (work[7] == mem[7]) && (sum9[7] != work[7]);
	assign and_res = work & mem;

	// keep all bits but the selected one
	genvar i;
	generate
		for (i = 0; i < `EXT_DATA_W; i++) begin : g_mask
			assign keep_mask[i] = (int'(bit_sel) != i);
		end
	endgenerate

	assign result = is_add ? sum9[`EXT_DATA_W-1:0] :
		is_and ? and_res :
		(op == far_clear_bit) ? (mem & keep_mask) : 8'h00;

	assign to_mem = (op != far_add_with_carry_to_work) && (op != far_add_to_work) &&
		(op != far_and_to_work);

	assign null_res = (result == 8'h00);

	// flag updates: adds touch all five, and only the null flag, clears none
	assign flags_out.wrap_out      = is_add ? sum9[`EXT_DATA_W] : flags_in.wrap_out;
	assign flags_out.half_carry    = is_add ? low5[4] : flags_in.half_carry;
	assign flags_out.signed_range  = is_add ? ovf : flags_in.signed_range;
	assign flags_out.signed_result = is_add ? (ovf ^ sum9[7]) : flags_in.signed_result;
	assign flags_out.result_null   = (is_add || is_and) ? null_res : flags_in.result_null;

endmodule // ext_alu_calc

// ---- rtl/extended_data_memory_alu.sv ----
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "ext_alu_defs.svh"

// What this block does
// - operand byte is addressed by section and offset, never limited to current section
// - add with carry to work: work plus byte plus carry, five flags updated
// - add with carry to memory: same sum written back to the byte, five flags
// - add to work: work plus byte, no carry, five flags updated
// - add to memory: work plus byte, no carry, written to byte, five flags
// - and to work: work and byte into work, only null flag changes
// - and to memory: work and byte into the byte, only null flag changes
// - byte clear writes zero to the byte, flags untouched
// - bit clear zeroes one selected bit, other bits and flags untouched
module extended_data_memory_alu
	import ext_alu_pkg::*;
(
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// apb slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [`APB_ADDR_W-1:0]   paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// instruction decoder side
	input  wire logic                     op_valid,
	input  wire ext_req_t                 op_req,
	output logic                          op_ready,
	output logic                          op_done,
	// data memory side
	output mem_cmd_t                      mem_cmd,
	input  wire logic                     mem_rvalid,
	input  wire logic [`EXT_DATA_W-1:0]   mem_rdata,
	// state seen by the rest of the core
	output logic      [`EXT_DATA_W-1:0]   work_register,
	output flags_t                        status_flags
);

	ext_state_t                 state_r;
	ext_state_t                 state_nxt;
	ext_req_t                   req_r;
	logic [`EXT_DATA_W-1:0]     mem_data_r;
	logic [`EXT_DATA_W-1:0]     work_r;
	flags_t                     flags_r;
	logic                       enable_r;
	logic [`STAT_COUNT_W-1:0]   count_r;
	ext_op_t                    last_op_r;
	logic                       op_ready_r;
	logic                       op_done_r;
	mem_cmd_t                   mem_cmd_r;
	logic [31:0]                prdata_r;
	logic                       pready_r;
	logic                       pslverr_r;

	// decoding
	logic                       accept;
	logic                       needs_read;
	logic                       exec_now;
	logic [`EXT_ADDR_W-1:0]     far_addr;
	logic [`EXT_ADDR_W-1:0]     req_addr;
	logic [`EXT_DATA_W-1:0]     calc_result;
	flags_t                     calc_flags;
	logic                       calc_to_mem;

	assign accept     = (state_r == st_idle) && op_valid && op_ready_r;
	assign needs_read = (op_req.op != far_clear_byte);
	assign exec_now   = (state_r == st_exec);
	assign far_addr   = {op_req.section, op_req.offset};
	assign req_addr   = {req_r.section, req_r.offset};

	// byte clear never needs the old value, so it skips the fetch
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			st_idle: begin
				if (accept) begin
					state_nxt = needs_read ? st_fetch : st_exec;
				end
			end
			st_fetch: begin
				if (mem_rvalid) begin
					state_nxt = st_exec;
				end
			end
			st_exec: begin
				state_nxt = st_idle;
			end
			default: begin
				state_nxt = st_idle;
			end
		endcase
	end

	ext_alu_calc u_calc (
		.op        (req_r.op),
		.work      (work_r),
		.mem       (mem_data_r),
		.flags_in  (flags_r),
		.bit_sel   (req_r.bit_sel),
		.result    (calc_result),
		.flags_out (calc_flags),
		.to_mem    (calc_to_mem)
	);

	// apb decode
	logic                       apb_setup;
	logic                       apb_access;
	logic                       apb_wr;
	logic                       hit_ctrl;
	logic                       hit_work;
	logic                       hit_flags;
	logic                       hit_status;
	logic                       hit_any;
	logic [31:0]                rd_mux;
	logic [31:0]                status_word;

	assign apb_setup  = psel && !penable;
	assign apb_access = psel && penable && pready_r;
	assign apb_wr     = apb_access && pwrite && !pslverr_r;
	assign hit_ctrl   = (paddr == `REG_CTRL_OFS);
	assign hit_work   = (paddr == `REG_WORK_OFS);
	assign hit_flags  = (paddr == `REG_FLAGS_OFS);
	assign hit_status = (paddr == `REG_STATUS_OFS);
	assign hit_any    = hit_ctrl || hit_work || hit_flags || hit_status;

	assign status_word = {16'h0000, count_r, 1'b0, last_op_r, 1'b0, state_r,
		(state_r != st_idle)};

	assign rd_mux = hit_ctrl  ? {31'h0, enable_r} :
		hit_work  ? {24'h000000, work_r} :
		hit_flags ? {27'h0000000, flags_r} :
		hit_status ? status_word : 32'h00000000;

	// answer is prepared in setup so the access phase completes at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h00000000;
		end else begin
			pready_r  <= apb_setup;
			pslverr_r <= apb_setup && !hit_any;
			prdata_r  <= (apb_setup && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_r <= `CTRL_RESET_VAL;
		end else if (apb_wr && hit_ctrl) begin
			enable_r <= pwdata[`CTRL_ENABLE_BIT];
		end
	end

	// sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r    <= st_idle;
			req_r      <= '0;
			mem_data_r <= 8'h00;
			op_ready_r <= 1'b0;
			op_done_r  <= 1'b0;
			mem_cmd_r  <= '0;
		end else begin
			state_r    <= state_nxt;
			op_ready_r <= (state_nxt == st_idle) && enable_r;
			op_done_r  <= exec_now;
			mem_cmd_r.rd <= accept && needs_read;
			mem_cmd_r.wr <= exec_now && calc_to_mem;
			if (accept) begin
				req_r          <= op_req;
				mem_cmd_r.addr <= far_addr;
			end
			if (state_r == st_fetch && mem_rvalid) begin
				mem_data_r <= mem_rdata;
			end
			if (exec_now) begin
				mem_cmd_r.addr  <= req_addr;
				mem_cmd_r.wdata <= calc_result;
			end
		end
	end

	// work and flags
	// an executing instruction wins over a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			work_r <= `WORK_RESET_VAL;
		end else if (exec_now && !calc_to_mem) begin
			work_r <= calc_result;
		end else if (apb_wr && hit_work) begin
			work_r <= pwdata[`EXT_DATA_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= `FLAGS_RESET_VAL;
		end else if (exec_now) begin
			flags_r <= calc_flags;
		end else if (apb_wr && hit_flags) begin
			flags_r <= pwdata[`FLAGS_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r   <= 8'h00;
			last_op_r <= far_add_with_carry_to_work;
		end else if (exec_now) begin
			count_r   <= count_r + 8'h01;
			last_op_r <= req_r.op;
		end
	end

	assign prdata        = prdata_r;
	assign pready        = pready_r;
	assign pslverr       = pslverr_r;
	assign op_ready      = op_ready_r;
	assign op_done       = op_done_r;
	assign mem_cmd       = mem_cmd_r;
	assign work_register = work_r;
	assign status_flags  = flags_r;

endmodule // extended_data_memory_alu

// ---- tb/ext_mem_model.sv ----
`timescale 1ns/1ns
module ext_mem_model
	import ext_alu_pkg::*;
(
	input  wire logic     pclk,
	input  wire logic     slow,
	input  wire mem_cmd_t mem_cmd,
	output logic          mem_rvalid,
	output logic [7:0]    mem_rdata
);
	logic [7:0] mem [0:2047];
	logic [1:0] cnt = 2'h0;
	initial mem_rvalid = 1'b0;
	initial mem_rdata = 8'h00;
	// outside a read the data lines toggle so a stale byte is never mistaken for data
	always @(posedge pclk) begin
		mem_rvalid <= cnt == 2'h1;
		mem_rdata <= cnt == 2'h1 ? mem[mem_cmd.addr] : ~mem_rdata;
		if (mem_cmd.wr)
			mem[mem_cmd.addr] <= mem_cmd.wdata;
		if (mem_cmd.rd)
			cnt <= slow ? 2'h3 : 2'h1;
		else if (cnt != 2'h0)
			cnt <= cnt - 2'h1;
	end
endmodule // ext_mem_model

// ---- tb/extended_data_memory_alu_props.sv ----
`timescale 1ns/1ns
module extended_data_memory_alu_props
	import ext_alu_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       op_valid,
	input wire ext_req_t   op_req,
	input wire logic       op_ready,
	input wire logic       op_done,
	input wire mem_cmd_t   mem_cmd,
	input wire logic       mem_rvalid,
	input wire logic [7:0] mem_rdata,
	input wire logic [7:0] work_register,
	input wire flags_t     status_flags
);
	wire        take = op_valid && op_ready;
	ext_op_t    op_r;
	logic [7:0] w_r;
	logic [7:0] rd_r;
	logic [2:0] bit_r;
	flags_t     f_r;
	wire  [7:0] res = op_r[0] ? mem_cmd.wdata : work_register;
	wire  [8:0] sum = {1'b0, w_r} + {1'b0, rd_r};
	// no reset needed: every consequent waits for a take first
	always_ff @(posedge pclk) begin
		if (take) begin
			op_r <= op_req.op;
			w_r <= work_register;
			f_r <= status_flags;
			bit_r <= op_req.bit_sel;
		end
		if (mem_rvalid)
			rd_r <= mem_rdata;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_RD_ADDR: assert property (
		take && op_req.op != far_clear_byte |=> mem_cmd.rd &&
		mem_cmd.addr == {$past(op_req.section), $past(op_req.offset)})
		else $error("read address wrong");
	AST_CLR_BYTE: assert property (
		take && op_req.op == far_clear_byte |-> ##2 op_done && mem_cmd.wr && mem_cmd.wdata == 8'h00)
		else $error("byte clear wrong");
	AST_CLR_FLAGS: assert property (
		op_done && op_r inside {far_clear_byte, far_clear_bit} |-> status_flags == f_r)
		else $error("clear touched flags");
	AST_BIT_CLR: assert property (
		op_done && op_r == far_clear_bit |-> mem_cmd.wr && mem_cmd.wdata == (rd_r & ~(8'h01 << bit_r)))
		else $error("bit clear wrong");
	AST_AND_WORK: assert property (
		op_done && op_r == far_and_to_work |-> work_register == (w_r & rd_r) &&
		status_flags == {f_r[4:3], work_register == 8'h00, f_r[1:0]})
		else $error("and to work wrong");
	AST_AND_MEM: assert property (
		op_done && op_r == far_and_to_memory |-> mem_cmd.wr && mem_cmd.wdata == (w_r & rd_r))
		else $error("and to memory wrong");
	AST_ADD_CARRY: assert property (
		op_done && op_r inside {far_add_with_carry_to_work, far_add_with_carry_to_memory}
		|-> {status_flags.wrap_out, res} == sum + 9'(f_r.wrap_out))
		else $error("carry add wrong");
	AST_ADD: assert property (
		op_done && op_r inside {far_add_to_work, far_add_to_memory} |->
		{status_flags.wrap_out, res} == sum && status_flags.result_null == (res == 8'h00))
		else $error("add wrong");
endmodule // extended_data_memory_alu_props

bind extended_data_memory_alu extended_data_memory_alu_props props_u (
	.pclk(pclk), .presetn(presetn), .op_valid(op_valid), .op_req(op_req),
	.op_ready(op_ready), .op_done(op_done), .mem_cmd(mem_cmd), .mem_rvalid(mem_rvalid),
	.mem_rdata(mem_rdata), .work_register(work_register), .status_flags(status_flags));

// ---- tb/extended_data_memory_alu_test.sv ----
`timescale 1ns/1ns
module extended_data_memory_alu_test
	import ext_alu_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, op_valid, slow;
	logic [7:0]  paddr, work_register, mem_rdata;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, op_ready, op_done, mem_rvalid;
	ext_req_t    op_req;
	mem_cmd_t    mem_cmd;
	flags_t      status_flags;
	int          err_count = 0;
	int          tests_run = 0;
	logic [15:0] rs = 16'h0024;

	extended_data_memory_alu dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_req(op_req),
		.op_ready(op_ready), .op_done(op_done), .mem_cmd(mem_cmd), .mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata), .work_register(work_register), .status_flags(status_flags));
	ext_mem_model mem_u (.pclk(pclk), .slow(slow), .mem_cmd(mem_cmd),
		.mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	function automatic logic [15:0] rnd();
		rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
		return rs;
	endfunction

	function automatic void calc(input ext_op_t o, input logic [7:0] m, input logic [2:0] b,
		inout logic [7:0] w, inout flags_t f, output logic [7:0] r);
		logic [8:0] s;
		logic       c;
		logic       v;
		c = o < 2 && f.wrap_out;
		s = {1'b0, w} + {1'b0, m} + 9'(c);
		v = w[7] == m[7] && s[7] != w[7];
		r = m;
		if (o < 4) begin
			f = '{v ^ s[7], v, s[7:0] == 8'h00,
				({1'b0, w[3:0]} + {1'b0, m[3:0]} + 5'(c)) > 5'h0f, s[8]};
			if (o[0])
				r = s[7:0];
			else
				w = s[7:0];
		end else if (o < 6) begin
			f.result_null = (w & m) == 8'h00;
			if (o[0])
				r = w & m;
			else
				w = w & m;
		end else if (o == far_clear_byte)
			r = 8'h00;
		else
			r = m & ~(8'h01 << b);
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		// one idle edge first, so a release and the next setup never share a time step
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic run(input ext_op_t o, input logic [10:0] a, input logic [2:0] b);
		int n = 0;
		op_valid <= 1'b1;
		op_req <= '{o, a[10:8], a[7:0], b};
		do @(posedge pclk); while (op_ready !== 1'b1 && ++n < 50);
		op_valid <= 1'b0;
		do @(posedge pclk); while (op_done !== 1'b1 && ++n < 50);
		if (n >= 50)
			err_count++;
	endtask

	task automatic test_done();
		$display("tests %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge pclk);
		err_count++;
		test_done();
	end

	initial begin
		logic [31:0] r;
		logic        e;
		logic [7:0]  w, m, em;
		logic [10:0] a;
		logic [2:0]  b;
		flags_t      f;
		ext_op_t     o;
		{presetn, psel, penable, pwrite, op_valid, slow} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		op_req = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(1'b0, 8'h00, 32'h0, r, e);
		chk(r, 32'h1);
		apb(1'b0, 8'h04, 32'h0, r, e);
		chk(r, 32'h0);
		apb(1'b0, 8'h08, 32'h0, r, e);
		chk(r, 32'h0);
		apb(1'b0, 8'h10, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1);
		$display("test registers done");
		// first sixteen passes use carry and overflow corners, the rest random bytes
		for (int n = 0; n < 48; n++) begin
			w = n < 8 ? 8'hff : n < 16 ? 8'h80 : 8'(rnd());
			m = n < 8 ? 8'h01 : n < 16 ? 8'h80 : 8'(rnd());
			f = flags_t'(5'(rnd()));
			a = 11'(rnd());
			b = 3'(rnd());
			slow <= rs[4];
			o = ext_op_t'(n[2:0]);
			apb(1'b1, 8'h04, 32'(w), r, e);
			apb(1'b1, 8'h08, 32'(f), r, e);
			mem_u.mem[a] = m;
			calc(o, m, b, w, f, em);
			run(o, a, b);
			chk(work_register, w);
			chk(status_flags, f);
			@(posedge pclk);
			chk(mem_u.mem[a], em);
		end
		// status: idle, last op bit clear, 48 operations counted
		apb(1'b0, 8'h0c, 32'h0, r, e);
		chk(r, 32'h00003070);
		$display("test operations done");
		apb(1'b1, 8'h00, 32'h0, r, e);
		// op_ready falls one edge after the enable write lands
		@(posedge pclk);
		op_valid <= 1'b1;
		repeat (6) begin
			@(posedge pclk);
			chk({op_ready, op_done}, 32'h0);
		end
		op_valid <= 1'b0;
		apb(1'b1, 8'h00, 32'h1, r, e);
		$display("test disable done");
		test_done();
	end
endmodule // extended_data_memory_alu_test
